// >>> uidh_map.vh
// register map, field positions and reset values of the second serial port
`ifndef UIDH_MAP_VH
`define UIDH_MAP_VH

// bus widths
`define UIDH_ADDR_W 32
`define UIDH_DATA_W 32

// byte addresses
`define UIDH_ADDR_DATA_DIV_LO 32'h50001100
`define UIDH_ADDR_INTR_EN_DIV_HI 32'h50001104
`define UIDH_ADDR_LINE_CTRL 32'h5000110c
`define UIDH_ADDR_EVT_STATUS 32'h50001120
`define UIDH_ADDR_EVT_CLEAR 32'h50001124
`define UIDH_ADDR_EVT_ENABLE 32'h50001128
`define UIDH_ADDR_SRC_VIEW 32'h5000112c

// interrupt enable fields, divisor latch access off
`define UIDH_BIT_RX_AVAIL_EN 0
`define UIDH_BIT_TX_EMPTY_EN 1
`define UIDH_BIT_LINE_STAT_EN 2
`define UIDH_BIT_MODEM_STAT_EN 3
`define UIDH_BIT_PROG_EMPTY_EN 7
`define UIDH_INTR_EN_MASK 8'h8f

// line control field
`define UIDH_BIT_DIV_ACCESS 7

// divisor
`define UIDH_DIV_W 16
`define UIDH_OVERSAMPLE_W 4

// event status bits
`define UIDH_EVT_W 3
`define UIDH_EVT_DIV_LOAD 0
`define UIDH_EVT_PORT_INTR 1
`define UIDH_EVT_RSVD_WRITE 2

// pending source codes, highest priority first
`define UIDH_SRC_W 3
`define UIDH_SRC_NONE 3'h0
`define UIDH_SRC_LINE_STAT 3'h1
`define UIDH_SRC_RX_AVAIL 3'h2
`define UIDH_SRC_CHAR_TMO 3'h3
`define UIDH_SRC_TX_EMPTY 3'h4
`define UIDH_SRC_MODEM_STAT 3'h5

// reset values
`define UIDH_RST_BYTE 8'h00
`define UIDH_RST_WORD 32'h00000000
`define UIDH_RST_EVT 3'h0

`endif

// >>> uidh_baud_gen.v
// baud tick generator: divisor down-counter and sixteen-times oversample count
`timescale 1ns/1ps
`default_nettype none
`include "uidh_map.vh"

module uidh_baud_gen #(
   parameter DIV_W = `UIDH_DIV_W,
   parameter OVS_W = `UIDH_OVERSAMPLE_W
) (
   // clock and reset
   input wire mclk_in,
   input wire rstn_in,
   // divisor
   input wire [DIV_W-1:0] divisor_in,
   input wire restart_in,
   // ticks
   output wire sample_tick_out,
   output wire baud_tick_out,
   output wire running_out
);

   reg [DIV_W-1:0] cnt_ff;
   reg [DIV_W-1:0] nxt_cnt;
   reg [OVS_W-1:0] ovs_ff;
   reg [OVS_W-1:0] nxt_ovs;
   reg sample_ff;
   reg baud_ff;
   wire running;
   wire wrap;

   // an all-zero divisor halts every tick
   assign running = |divisor_in;
   assign wrap = running && (cnt_ff == {DIV_W{1'b0}});

   always @* begin
      nxt_cnt = cnt_ff;
      nxt_ovs = ovs_ff;
      if (restart_in || !running) begin
         // restart so a new divisor never finishes a stale period
         nxt_cnt = {DIV_W{1'b0}};
         nxt_ovs = {OVS_W{1'b0}};
      end else if (wrap) begin
         nxt_cnt = divisor_in - {{(DIV_W-1){1'b0}}, 1'b1};
         nxt_ovs = ovs_ff + {{(OVS_W-1){1'b0}}, 1'b1};
      end else begin
         nxt_cnt = cnt_ff - {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         cnt_ff <= {DIV_W{1'b0}};
         ovs_ff <= {OVS_W{1'b0}};
         sample_ff <= 1'b0;
         baud_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ovs_ff <= nxt_ovs;
         sample_ff <= wrap && !restart_in;
         baud_ff <= wrap && !restart_in && (&ovs_ff);
      end
   end

   assign sample_tick_out = sample_ff;
   assign baud_tick_out = baud_ff;
   assign running_out = running;

endmodule
`default_nettype wire

// >>> uidh_ier_dlh.v
// interrupt enable / divisor high register of the second serial port
`timescale 1ns/1ps
`default_nettype none
`include "uidh_map.vh"

module uidh_ier_dlh #(
   parameter AW = `UIDH_ADDR_W,
   parameter DW = `UIDH_DATA_W
) (
   // clock and reset
   input wire mclk_in,
   input wire rstn_in,
   // register port
   input wire [AW-1:0] addr_in,
   input wire [DW-1:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output wire [DW-1:0] rdata_out,
   // interrupt conditions from the port logic
   input wire line_status_cond_in,
   input wire rx_data_avail_cond_in,
   input wire char_timeout_cond_in,
   input wire fifo_en_in,
   input wire tx_holding_empty_cond_in,
   input wire modem_status_cond_in,
   // data path toward the shifters
   input wire [7:0] rx_data_in,
   output wire [7:0] tx_data_out,
   output wire tx_data_wr_out,
   output wire rx_data_rd_out,
   // port control state
   output wire prog_empty_intr_mode_en_out,
   output wire divisor_latch_access_out,
   output wire [`UIDH_DIV_W-1:0] divisor_out,
   output wire sample_tick_out,
   output wire baud_tick_out,
   output wire baud_running_out,
   // interrupts
   output wire [`UIDH_SRC_W-1:0] intr_src_id_out,
   output wire port_intr_out,
   output wire evt_irq_out
);

   // stored state
   reg [7:0] intr_en_ff;
   reg [7:0] div_lo_ff;
   reg [7:0] div_hi_ff;
   reg [7:0] line_control_reg_ff;
   reg [DW-1:0] rdata_ff;
   reg [7:0] tx_data_ff;
   reg tx_wr_ff;
   reg rx_rd_ff;
   reg [`UIDH_SRC_W-1:0] src_id_ff;
   reg port_intr_ff;
   reg [`UIDH_EVT_W-1:0] evt_stat_ff;
   reg [`UIDH_EVT_W-1:0] evt_en_ff;

   // next values
   reg [7:0] nxt_intr_en;
   reg [7:0] nxt_div_lo;
   reg [7:0] nxt_div_hi;
   reg [7:0] nxt_line_control_reg;
   reg [DW-1:0] nxt_rdata;
   reg [`UIDH_SRC_W-1:0] nxt_src_id;
   reg [`UIDH_EVT_W-1:0] nxt_evt_stat;
   reg [`UIDH_EVT_W-1:0] evt_set;

   // decode
   wire sel_data;
   wire sel_intr_en;
   wire sel_lc;
   wire sel_evt_stat;
   wire sel_evt_clr;
   wire sel_evt_en;
   wire sel_view;
   wire div_access;
   wire div_load;
   wire [7:0] wbyte;

   // gated sources
   wire line_stat_req;
   wire rx_avail_req;
   wire char_tmo_req;
   wire tx_empty_req;
   wire modem_stat_req;
   wire any_req;

   assign sel_data = (addr_in == `UIDH_ADDR_DATA_DIV_LO);
   assign sel_intr_en = (addr_in == `UIDH_ADDR_INTR_EN_DIV_HI);
   assign sel_lc = (addr_in == `UIDH_ADDR_LINE_CTRL);
   assign sel_evt_stat = (addr_in == `UIDH_ADDR_EVT_STATUS);
   assign sel_evt_clr = (addr_in == `UIDH_ADDR_EVT_CLEAR);
   assign sel_evt_en = (addr_in == `UIDH_ADDR_EVT_ENABLE);
   assign sel_view = (addr_in == `UIDH_ADDR_SRC_VIEW);
   assign wbyte = wdata_in[7:0];

   assign div_access = line_control_reg_ff[`UIDH_BIT_DIV_ACCESS];
   // any divisor byte write restarts the baud counters
   assign div_load = wr_in && div_access && (sel_data || sel_intr_en);

   // source gating; conditions live outside and are never cleared here
   assign line_stat_req = line_status_cond_in &&
      intr_en_ff[`UIDH_BIT_LINE_STAT_EN];
   assign rx_avail_req = rx_data_avail_cond_in &&
      intr_en_ff[`UIDH_BIT_RX_AVAIL_EN];
   assign char_tmo_req = char_timeout_cond_in && fifo_en_in &&
      intr_en_ff[`UIDH_BIT_RX_AVAIL_EN];
   assign tx_empty_req = tx_holding_empty_cond_in &&
      intr_en_ff[`UIDH_BIT_TX_EMPTY_EN];
   assign modem_stat_req = modem_status_cond_in &&
      intr_en_ff[`UIDH_BIT_MODEM_STAT_EN];
   assign any_req = line_stat_req || rx_avail_req || char_tmo_req ||
      tx_empty_req || modem_stat_req;

   // register writes
   always @* begin
      nxt_intr_en = intr_en_ff;
      nxt_div_lo = div_lo_ff;
      nxt_div_hi = div_hi_ff;
      nxt_line_control_reg = line_control_reg_ff;
      if (wr_in) begin
         if (sel_intr_en && div_access) begin
            nxt_div_hi = wbyte;
         end else if (sel_intr_en) begin
            // bits 6:4 are not stored while they are reserved
            nxt_intr_en = wbyte & `UIDH_INTR_EN_MASK;
         end
         if (sel_data && div_access) begin
            nxt_div_lo = wbyte;
         end
         if (sel_lc) begin
            nxt_line_control_reg = wbyte;
         end
      end
   end

   // priority encode of enabled sources for the identification logic
   always @* begin
      if (line_stat_req) begin
         nxt_src_id = `UIDH_SRC_LINE_STAT;
      end else if (rx_avail_req) begin
         nxt_src_id = `UIDH_SRC_RX_AVAIL;
      end else if (char_tmo_req) begin
         nxt_src_id = `UIDH_SRC_CHAR_TMO;
      end else if (tx_empty_req) begin
         nxt_src_id = `UIDH_SRC_TX_EMPTY;
      end else if (modem_stat_req) begin
         nxt_src_id = `UIDH_SRC_MODEM_STAT;
      end else begin
         nxt_src_id = `UIDH_SRC_NONE;
      end
   end

   // sticky events; a set in the clearing cycle survives
   always @* begin
      evt_set = `UIDH_RST_EVT;
      evt_set[`UIDH_EVT_DIV_LOAD] = div_load;
      evt_set[`UIDH_EVT_PORT_INTR] = any_req && !port_intr_ff;
      evt_set[`UIDH_EVT_RSVD_WRITE] = wr_in && sel_intr_en && !div_access &&
         (|(wbyte & ~`UIDH_INTR_EN_MASK));
      nxt_evt_stat = evt_stat_ff;
      if (wr_in && sel_evt_clr) begin
         nxt_evt_stat = evt_stat_ff & ~wdata_in[`UIDH_EVT_W-1:0];
      end
      nxt_evt_stat = nxt_evt_stat | evt_set;
   end

   // read mux; data stands only in the cycle after the strobe
   always @* begin
      nxt_rdata = `UIDH_RST_WORD;
      if (rd_in) begin
         if (sel_intr_en && div_access) begin
            nxt_rdata[7:0] = div_hi_ff;
         end else if (sel_intr_en) begin
            nxt_rdata[7:0] = intr_en_ff;
         end else if (sel_data && div_access) begin
            nxt_rdata[7:0] = div_lo_ff;
         end else if (sel_data) begin
            nxt_rdata[7:0] = rx_data_in;
         end else if (sel_lc) begin
            nxt_rdata[7:0] = line_control_reg_ff;
         end else if (sel_evt_stat) begin
            nxt_rdata[`UIDH_EVT_W-1:0] = evt_stat_ff;
         end else if (sel_evt_en) begin
            nxt_rdata[`UIDH_EVT_W-1:0] = evt_en_ff;
         end else if (sel_view) begin
            // raw conditions beside the gated view, so masking can be checked
            nxt_rdata[7:0] = {port_intr_ff, src_id_ff, modem_status_cond_in,
               tx_holding_empty_cond_in, rx_data_avail_cond_in,
               line_status_cond_in};
         end
      end
   end

   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         intr_en_ff <= `UIDH_RST_BYTE;
         div_lo_ff <= `UIDH_RST_BYTE;
         div_hi_ff <= `UIDH_RST_BYTE;
         line_control_reg_ff <= `UIDH_RST_BYTE;
         rdata_ff <= `UIDH_RST_WORD;
         tx_data_ff <= `UIDH_RST_BYTE;
         tx_wr_ff <= 1'b0;
         rx_rd_ff <= 1'b0;
         src_id_ff <= `UIDH_SRC_NONE;
         port_intr_ff <= 1'b0;
         evt_stat_ff <= `UIDH_RST_EVT;
         evt_en_ff <= `UIDH_RST_EVT;
      end else begin
         intr_en_ff <= nxt_intr_en;
         div_lo_ff <= nxt_div_lo;
         div_hi_ff <= nxt_div_hi;
         line_control_reg_ff <= nxt_line_control_reg;
         rdata_ff <= nxt_rdata;
         // the data location reaches the shifters only with divisor access off
         if (wr_in && sel_data && !div_access) begin
            tx_data_ff <= wbyte;
         end
         tx_wr_ff <= wr_in && sel_data && !div_access;
         rx_rd_ff <= rd_in && sel_data && !div_access;
         src_id_ff <= nxt_src_id;
         port_intr_ff <= any_req;
         evt_stat_ff <= nxt_evt_stat;
         if (wr_in && sel_evt_en) begin
            evt_en_ff <= wdata_in[`UIDH_EVT_W-1:0];
         end
      end
   end

   uidh_baud_gen #(
      .DIV_W(`UIDH_DIV_W),
      .OVS_W(`UIDH_OVERSAMPLE_W)
   ) u_baud (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .divisor_in({div_hi_ff, div_lo_ff}),
      .restart_in(div_load),
      .sample_tick_out(sample_tick_out),
      .baud_tick_out(baud_tick_out),
      .running_out(baud_running_out)
   );

   assign rdata_out = rdata_ff;
   assign tx_data_out = tx_data_ff;
   assign tx_data_wr_out = tx_wr_ff;
   assign rx_data_rd_out = rx_rd_ff;
   assign prog_empty_intr_mode_en_out =
      intr_en_ff[`UIDH_BIT_PROG_EMPTY_EN];
   assign divisor_latch_access_out = div_access;
   assign divisor_out = {div_hi_ff, div_lo_ff};
   assign intr_src_id_out = src_id_ff;
   assign port_intr_out = port_intr_ff;
   assign evt_irq_out = |(evt_stat_ff & evt_en_ff);

endmodule
`default_nettype wire

// >>> uidh_ier_dlh_props.sv
// assertion checker for the interrupt enable / divisor high register
`timescale 1ns/1ps
`default_nettype none
module uidh_props (
   // clock, reset, bus
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   // sources
   input wire logic line_status_cond_in,
   input wire logic rx_data_avail_cond_in,
   input wire logic char_timeout_cond_in,
   input wire logic fifo_en_in,
   input wire logic tx_holding_empty_cond_in,
   input wire logic modem_status_cond_in,
   // state
   input wire logic prog_empty_intr_mode_en_out,
   input wire logic divisor_latch_access_out,
   input wire logic [15:0] divisor_out,
   input wire logic baud_running_out,
   input wire logic sample_tick_out,
   input wire logic baud_tick_out,
   input wire logic [2:0] intr_src_id_out,
   input wire logic port_intr_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   wire logic hit = addr_in == 32'h50001104;
   wire logic dla = divisor_latch_access_out;
   // shadow of the stored enables, so a masked source is never expected
   logic [7:0] en_sh;
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         en_sh <= 8'h00;
      end else if (wr_in && hit && !dla) begin
         en_sh <= wdata_in[7:0] & 8'h8f;
      end
   end
   wire logic ls = line_status_cond_in & en_sh[2];
   // timeout only counts with fifos on
   wire logic rx2 = (rx_data_avail_cond_in |
      (char_timeout_cond_in & fifo_en_in)) & en_sh[0];
   wire logic tx = tx_holding_empty_cond_in & en_sh[1];
   wire logic md = modem_status_cond_in & en_sh[3];
   wire logic any = ls | rx2 | tx | md;
   a_mode_bit_write: assert property (wr_in && hit && !dla |=>
      prog_empty_intr_mode_en_out == $past(wdata_in[7]))
      else $error("mode enable bit not written");
   a_div_hi_write: assert property (wr_in && hit && dla |=>
      divisor_out[15:8] == $past(wdata_in[7:0]) &&
      $stable(prog_empty_intr_mode_en_out))
      else $error("divisor high byte not written");
   a_div_hi_held: assert property (wr_in && hit && !dla |=>
      $stable(divisor_out[15:8])) else $error("divisor changed");
   a_ier_read_mask: assert property ($past(rd_in && hit && !dla) |->
      rdata_out[31:8] == 24'h0 && rdata_out[6:4] == 3'h0)
      else $error("reserved enable bits read nonzero");
   a_div_hi_read: assert property ($past(rd_in && hit && dla) |->
      rdata_out == {24'h0, divisor_out[15:8]})
      else $error("divisor high read wrong");
   a_top_prio: assert property (intr_src_id_out == 3'h1 |->
      $past(ls)) else $error("line status id without cause");
   a_second_prio: assert property (intr_src_id_out == 3'h3 |->
      $past(char_timeout_cond_in && fifo_en_in && en_sh[0] && !ls &&
      !rx_data_avail_cond_in)) else $error("timeout id wrong");
   a_third_prio: assert property (intr_src_id_out == 3'h4 |->
      $past(tx && !ls && !rx2)) else $error("tx empty id wrong");
   a_fourth_prio: assert property (intr_src_id_out == 3'h5 |->
      $past(md && !ls && !rx2 && !tx))
      else $error("modem id wrong");
   a_intr_needs_src: assert property (port_intr_out |->
      $past(any) && intr_src_id_out != 3'h0)
      else $error("interrupt without source");
   a_zero_div_stop: assert property (divisor_out == 16'h0 |->
      !baud_running_out ##1 (!sample_tick_out && !baud_tick_out))
      else $error("baud runs with zero divisor");
endmodule
bind uidh_ier_dlh uidh_props u_props (.mclk_in(mclk_in), .rstn_in(rstn_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .line_status_cond_in(line_status_cond_in),
   .rx_data_avail_cond_in(rx_data_avail_cond_in),
   .char_timeout_cond_in(char_timeout_cond_in), .fifo_en_in(fifo_en_in),
   .tx_holding_empty_cond_in(tx_holding_empty_cond_in),
   .modem_status_cond_in(modem_status_cond_in),
   .prog_empty_intr_mode_en_out(prog_empty_intr_mode_en_out),
   .divisor_latch_access_out(divisor_latch_access_out),
   .divisor_out(divisor_out), .baud_running_out(baud_running_out),
   .sample_tick_out(sample_tick_out), .baud_tick_out(baud_tick_out),
   .intr_src_id_out(intr_src_id_out), .port_intr_out(port_intr_out));
`default_nettype wire

// >>> uart_int_enable_divisor_high_tb_top.sv
// self-checking bench for the interrupt enable / divisor high register
`timescale 1ns/1ps
`default_nettype none
`include "uidh_map.vh"
module uart_int_enable_divisor_high_tb_top;
   logic mclk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic [31:0] addr_in = 32'h0, wdata_in = 32'h0, rdata_out;
   logic [5:0] cond = 6'h0; // line, rx, timeout, fifo, tx, modem
   logic [7:0] tx_data_out;
   logic [15:0] divisor_out;
   logic [2:0] src_id;
   logic pe, dla, btick, run, pintr, eirq, stick, txwr, rxrd;
   int n_fail = 0, checked = 0, n;
   localparam logic [31:0] A_IER = `UIDH_ADDR_INTR_EN_DIV_HI;
   localparam logic [31:0] A_LO = `UIDH_ADDR_DATA_DIV_LO;
   localparam logic [31:0] A_LC = `UIDH_ADDR_LINE_CTRL;
   localparam logic [16:0] TAB [8] = '{{8'h04, 6'h3f, 3'h1},
      {8'h01, 6'h3f, 3'h2}, {8'h01, 6'h0c, 3'h3}, {8'h01, 6'h08, 3'h0},
      {8'h02, 6'h3f, 3'h4}, {8'h08, 6'h3f, 3'h5}, {8'h00, 6'h3f, 3'h0},
      {8'h08, 6'h3f, 3'h5}};
   always #12.5 mclk_in = ~mclk_in;
   uidh_ier_dlh dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .line_status_cond_in(cond[5]),
      .rx_data_avail_cond_in(cond[4]), .char_timeout_cond_in(cond[3]),
      .fifo_en_in(cond[2]), .tx_holding_empty_cond_in(cond[1]),
      .modem_status_cond_in(cond[0]), .rx_data_in(8'h5a),
      .tx_data_out(tx_data_out), .tx_data_wr_out(txwr),
      .rx_data_rd_out(rxrd),
      .prog_empty_intr_mode_en_out(pe), .divisor_latch_access_out(dla),
      .divisor_out(divisor_out), .sample_tick_out(stick),
      .baud_tick_out(btick),
      .baud_running_out(run), .intr_src_id_out(src_id),
      .port_intr_out(pintr), .evt_irq_out(eirq));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] exp);
      @(posedge mclk_in);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp);
   endtask
   task report_and_stop;
      $display("checks=%0d fails=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task t_enables;
      rdc(A_IER, 32'h0);
      chk(run, 1'b0);
      wr(A_IER, 32'hff);
      rdc(A_IER, 32'h8f);
      chk(pe, 1'b1);
      wr(A_IER, 32'h70);
      chk({pe, divisor_out}, 17'h0);
      $display("test enables done");
   endtask
   task t_sources;
      for (int i = 0; i < 8; i++) begin
         wr(A_IER, {24'h0, TAB[i][16:9]});
         @(posedge mclk_in) cond <= TAB[i][8:3];
         repeat (2) @(posedge mclk_in);
         #1 chk({pintr, src_id}, {TAB[i][2:0] != 3'h0, TAB[i][2:0]});
      end
      // masked conditions stay visible in the raw view
      rdc(`UIDH_ADDR_SRC_VIEW, 32'hdf);
      @(posedge mclk_in) cond <= 6'h0;
      $display("test sources done");
   endtask
   task t_divisor;
      wr(A_LC, 32'h80);
      wr(A_IER, 32'h12);
      wr(A_LO, 32'h34);
      chk(divisor_out, 16'h1234);
      rdc(A_IER, 32'h12);
      rdc(A_LO, 32'h34);
      chk(rxrd, 1'b0);
      wr(A_IER, 32'h0);
      wr(A_LO, 32'h0);
      chk({run, stick, btick}, 3'h0);
      wr(A_LO, 32'h2);
      // the divisor of two gives sixteen times two clocks per bit
      n = 0;
      while (!btick && n < 200) begin @(negedge mclk_in); n++; end
      n = 0;
      do begin @(negedge mclk_in); n++; end while (!btick && n < 200);
      chk(n, 32);
      wr(A_LC, 32'h0);
      wr(A_LO, 32'h77);
      chk({txwr, tx_data_out, divisor_out}, 25'h1770002);
      rdc(A_LO, 32'h5a);
      chk(rxrd, 1'b1);
      rdc(A_IER, 32'h08);
      $display("test divisor done");
   endtask
   task t_events;
      rdc(`UIDH_ADDR_EVT_STATUS, 32'h7);
      wr(`UIDH_ADDR_EVT_ENABLE, 32'h1);
      chk(eirq, 1'b1);
      wr(`UIDH_ADDR_EVT_ENABLE, 32'h0);
      chk(eirq, 1'b0);
      wr(`UIDH_ADDR_EVT_CLEAR, 32'h7);
      rdc(`UIDH_ADDR_EVT_STATUS, 32'h0);
      wr(32'h50001130, 32'hff);
      rdc(32'h50001130, 32'h0);
      $display("test events done");
   endtask
   initial begin
      repeat (12) @(posedge mclk_in);
      rstn_in <= 1'b1;
      t_enables;
      t_sources;
      t_divisor;
      t_events;
      report_and_stop;
   end
   // the tests take under two thousand cycles
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_fail++;
      report_and_stop;
   end
endmodule
`default_nettype wire
